// file: hw/port_pin_consts.vh
// Constants for the two-port pin configuration block: register addresses,
// register pages, reset values and bit-address fields.
// Assumes the includer uses the paged special-function register bus.
`ifndef PORT_PIN_CONSTS_VH
`define PORT_PIN_CONSTS_VH

// ==========================================================================
// Register pages
`define PAGE_BASE 8'h00
`define PAGE_ALT 8'h0f

// ==========================================================================
// Register addresses (data latches answer in every page)
`define ADDR_PORT_A_DATA 8'ha0
`define ADDR_PORT_B_DRIVE 8'ha1
`define ADDR_PORT_A_OUTMODE 8'ha6
`define ADDR_PORT_A_DRIVE 8'ha6
`define ADDR_PORT_B_DATA 8'hb0
`define ADDR_PORT_B_OUTMODE 8'hb1
`define ADDR_PORT_B_INMODE 8'hf1
`define ADDR_PORT_A_INMODE 8'hf3

// ==========================================================================
// Bit addressing: upper five bits of a bit address name the byte
`define BIT_BYTE_MSB 7
`define BIT_BYTE_LSB 3
`define BIT_IDX_MSB 2
`define BITBYTE_PORT_A 5'h14
`define BITBYTE_PORT_B 5'h16

// ==========================================================================
// Reset values
`define RST_DATA 8'hff
`define RST_INMODE 8'hff
`define RST_OUTMODE 8'h00
`define RST_DRIVE 8'h00
`define RST_READ 8'h00

// ==========================================================================
// Port A input mode: bit 7 is reserved and always reads as one
`define PORT_A_RSVD_BIT 7
`define PORT_A_MODE_BITS 7

`endif

// file: hw/port_pin_cell.v
// One port of pin cells: turns latch and mode bits into pad controls and
// brings the pad levels back in through a two-stage synchroniser.
// Assumes pad inputs are asynchronous to clk.
`timescale 1ns/1ns
`include "port_pin_consts.vh"
module port_pin_cell #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Configuration from the register file
  input wire [WIDTH-1:0] latch,
  input wire [WIDTH-1:0] digitalMode,
  input wire [WIDTH-1:0] pushPull,
  input wire [WIDTH-1:0] highDrive,
  // Pad side
  input wire [WIDTH-1:0] padIn,
  output reg [WIDTH-1:0] padOut,
  output reg [WIDTH-1:0] padOe,
  output reg [WIDTH-1:0] padPullupEn,
  output reg [WIDTH-1:0] padRxEn,
  output reg [WIDTH-1:0] padHighDrive,
  // Level seen by software
  output reg [WIDTH-1:0] pinLevel
);

  reg [WIDTH-1:0] padMeta;
  reg [WIDTH-1:0] padSync;

  // ========================================================================
  // Synchroniser; only the second stage is read by logic
  always @(posedge clk) begin
    if (rst) begin
      padMeta <= {WIDTH{1'b1}};
      padSync <= {WIDTH{1'b1}};
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // ========================================================================
  // Pad controls, registered so the pads never see decode glitches
  always @(posedge clk) begin
    if (rst) begin
      padOut <= `RST_DATA;
      padOe <= `RST_OUTMODE;
      padPullupEn <= `RST_INMODE;
      padRxEn <= `RST_INMODE;
      padHighDrive <= `RST_DRIVE;
      pinLevel <= `RST_READ;
    end else begin
      padOut <= latch;
      // Open-drain only pulls low; push-pull drives both ways [R05] [R06]
      // Driver follows output mode regardless of analog mode [R03] [R07]
      padOe <= pushPull | ~latch;
      // Analog mode turns off weak pull-up and receiver [R03]
      padPullupEn <= digitalMode;
      padRxEn <= digitalMode;
      padHighDrive <= highDrive; // [R08] [R09]
      // Receiver off reads as zero [R15]
      pinLevel <= padSync & digitalMode;
    end
  end

endmodule

// file: hw/port2_port3_pin_config.v
// Pin configuration and data registers for two 8-bit general-purpose
// ports, reached over the paged special-function register bus.
// Assumes one bus access per cycle and pads outside that resolve the
// output enable, pull-up enable and drive strength into the pin level.
`timescale 1ns/1ns
`include "port_pin_consts.vh"

// Operation
// R01: Port A input-mode bit 7 reads one
// R02: Port A input-mode bits 6:0 pick analog/digital
// R03: Analog turns off pull-up and receiver only
// R04: Port B input-mode bits 7:0 pick analog/digital
// R05: Port A output-mode bit: open-drain or push-pull
// R06: Port B output-mode bit: open-drain or push-pull
// R07: Output mode drives pin even in analog
// R08: Port A drive bit selects low/high drive
// R09: Port B drive bit selects low/high drive
// R10: Port B data: write latch, read pins
// R11: Data bit zero drives low, one high
// R12: Port B data at 0xb0, bit-addressable
// R13: Address 0xa6 split by page
// R14: Port A data at 0xa0, write latch, read pins
// R15: Analog pins read back as zero
module port2_port3_pin_config #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Byte access on the register bus
  input wire [7:0] sfrPage,
  input wire [7:0] sfrAddr,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrWdata,
  output reg [7:0] sfrRdata,
  output reg sfrAck,
  // Bit access on the register bus
  input wire [7:0] sfrBitAddr,
  input wire sfrBitWrite,
  input wire sfrBitRead,
  input wire sfrBitWdata,
  output reg sfrBitRdata,
  // Port A pads
  input wire [WIDTH-1:0] portAIn,
  output wire [WIDTH-1:0] portAOut,
  output wire [WIDTH-1:0] portAOe,
  output wire [WIDTH-1:0] portAPullupEn,
  output wire [WIDTH-1:0] portARxEn,
  output wire [WIDTH-1:0] portAHighDrive,
  // Port B pads
  input wire [WIDTH-1:0] portBIn,
  output wire [WIDTH-1:0] portBOut,
  output wire [WIDTH-1:0] portBOe,
  output wire [WIDTH-1:0] portBPullupEn,
  output wire [WIDTH-1:0] portBRxEn,
  output wire [WIDTH-1:0] portBHighDrive
);

  // ========================================================================
  // Register state
  reg [7:0] port_a_data_latch;
  reg [6:0] port_a_input_mode;
  reg [7:0] port_a_output_mode;
  reg [7:0] port_a_drive_strength;
  reg [7:0] port_b_data_latch;
  reg [7:0] port_b_input_mode;
  reg [7:0] port_b_output_mode;
  reg [7:0] port_b_drive_strength;

  // Pin levels after synchronising and analog masking
  wire [WIDTH-1:0] portALevel;
  wire [WIDTH-1:0] portBLevel;

  // Full input-mode vector for port A; pin 7 has no analog option
  wire [7:0] portADigital;

  // ========================================================================
  // Address decode
  wire pageBase;
  wire pageAlt;
  wire selADataByte;
  wire selAInMode;
  wire selAOutMode;
  wire selADrive;
  wire selBDataByte;
  wire selBInMode;
  wire selBOutMode;
  wire selBDrive;
  wire anySel;
  wire [4:0] bitByte;
  wire [2:0] bitIdx;
  wire bitSelA;
  wire bitSelB;

  assign pageBase = (sfrPage == `PAGE_BASE);
  assign pageAlt = (sfrPage == `PAGE_ALT);
  // Data latches ignore the page so every page reaches them [R12] [R14]
  assign selADataByte = (sfrAddr == `ADDR_PORT_A_DATA);
  assign selBDataByte = (sfrAddr == `ADDR_PORT_B_DATA);
  assign selAInMode = pageBase && (sfrAddr == `ADDR_PORT_A_INMODE);
  // Same address, the page picks which register answers [R13]
  assign selAOutMode = pageBase && (sfrAddr == `ADDR_PORT_A_OUTMODE);
  assign selADrive = pageAlt && (sfrAddr == `ADDR_PORT_A_DRIVE);
  assign selBInMode = pageAlt && (sfrAddr == `ADDR_PORT_B_INMODE);
  assign selBOutMode = pageAlt && (sfrAddr == `ADDR_PORT_B_OUTMODE);
  assign selBDrive = pageAlt && (sfrAddr == `ADDR_PORT_B_DRIVE);
  assign anySel = selADataByte | selBDataByte | selAInMode | selAOutMode |
    selADrive | selBInMode | selBOutMode | selBDrive;

  // Bit addresses: upper bits name the byte, low bits the pin [R12]
  assign bitByte = sfrBitAddr[`BIT_BYTE_MSB:`BIT_BYTE_LSB];
  assign bitIdx = sfrBitAddr[`BIT_IDX_MSB:0];
  assign bitSelA = (bitByte == `BITBYTE_PORT_A);
  assign bitSelB = (bitByte == `BITBYTE_PORT_B);

  // Reserved bit 7 reads as one and acts as a digital pin [R01]
  assign portADigital = {1'b1, port_a_input_mode};

  // ========================================================================
  // Write enables, one per register plus a bit enable per data latch; the byte enables of the data latches
  // also block a bit write that lands on the same latch in the same cycle
  wire wrAData;
  wire wrBData;
  wire wrABit;
  wire wrBBit;
  wire wrAInMode;
  wire wrAOutMode;
  wire wrADrive;
  wire wrBInMode;
  wire wrBOutMode;
  wire wrBDrive;

  assign wrAData = sfrWrite && selADataByte;
  assign wrBData = sfrWrite && selBDataByte;
  // A bit write only counts when no byte write hits the same latch
  assign wrABit = sfrBitWrite && bitSelA && !wrAData;
  assign wrBBit = sfrBitWrite && bitSelB && !wrBData;
  assign wrAInMode = sfrWrite && selAInMode;
  assign wrAOutMode = sfrWrite && selAOutMode;
  assign wrADrive = sfrWrite && selADrive;
  assign wrBInMode = sfrWrite && selBInMode;
  assign wrBOutMode = sfrWrite && selBOutMode;
  assign wrBDrive = sfrWrite && selBDrive;

  // ========================================================================
  // Data latches; a byte write wins over a bit write in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      port_a_data_latch <= `RST_DATA;
      port_b_data_latch <= `RST_DATA;
    end else begin
      // Port A latch
      if (wrAData) begin
        port_a_data_latch <= sfrWdata; // [R14] [R11]
      end else if (wrABit) begin
        port_a_data_latch[bitIdx] <= sfrBitWdata; // [R14] [R11]
      end
      // Port B latch
      if (wrBData) begin
        port_b_data_latch <= sfrWdata; // [R10] [R11]
      end else if (wrBBit) begin
        port_b_data_latch[bitIdx] <= sfrBitWdata; // [R10] [R12]
      end
    end
  end

  // ========================================================================
  // Port A configuration registers
  // Full reset value, so the stored bits 6:0 can be cut from it on purpose
  localparam [7:0] RST_A_INMODE = `RST_INMODE;

  always @(posedge clk) begin
    if (rst) begin
      port_a_input_mode <= RST_A_INMODE[`PORT_A_MODE_BITS-1:0];
      port_a_output_mode <= `RST_OUTMODE;
      port_a_drive_strength <= `RST_DRIVE;
    end else begin
      if (wrAInMode) begin
        // Only bits 6:0 are stored; bit 7 is fixed at one [R02] [R01]
        port_a_input_mode <= sfrWdata[`PORT_A_MODE_BITS-1:0];
      end
      if (wrAOutMode) begin
        port_a_output_mode <= sfrWdata; // [R05] [R13]
      end
      if (wrADrive) begin
        port_a_drive_strength <= sfrWdata; // [R08] [R13]
      end
    end
  end

  // ========================================================================
  // Port B configuration registers
  always @(posedge clk) begin
    if (rst) begin
      port_b_input_mode <= `RST_INMODE;
      port_b_output_mode <= `RST_OUTMODE;
      port_b_drive_strength <= `RST_DRIVE;
    end else begin
      // All three live in the alternate page only
      if (wrBInMode) begin
        port_b_input_mode <= sfrWdata; // [R04]
      end
      if (wrBOutMode) begin
        port_b_output_mode <= sfrWdata; // [R06]
      end
      if (wrBDrive) begin
        port_b_drive_strength <= sfrWdata; // [R09]
      end
    end
  end

  // ========================================================================
  // Byte read mux; unmapped addresses answer zero with no acknowledge
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `RST_READ;
    if (selADataByte) begin
      next_rdata = portALevel; // [R14] [R15]
    end else if (selBDataByte) begin
      next_rdata = portBLevel; // [R10] [R15]
    end else if (selAInMode) begin
      next_rdata = portADigital; // [R01]
    end else if (selAOutMode) begin
      next_rdata = port_a_output_mode;
    end else if (selADrive) begin
      next_rdata = port_a_drive_strength;
    end else if (selBInMode) begin
      next_rdata = port_b_input_mode;
    end else if (selBOutMode) begin
      next_rdata = port_b_output_mode;
    end else if (selBDrive) begin
      next_rdata = port_b_drive_strength;
    end
  end

  // Read data registered; it holds until the next read
  always @(posedge clk) begin
    if (rst) begin
      sfrRdata <= `RST_READ;
      sfrAck <= 1'b0;
    end else begin
      sfrAck <= (sfrRead | sfrWrite) & anySel;
      if (sfrRead) begin
        sfrRdata <= next_rdata;
      end
    end
  end

  // ========================================================================
  // Bit read returns the pin level, not the latch
  always @(posedge clk) begin
    if (rst) begin
      sfrBitRdata <= 1'b0;
    end else if (sfrBitRead) begin
      if (bitSelA) begin
        sfrBitRdata <= portALevel[bitIdx]; // [R14]
      end else if (bitSelB) begin
        sfrBitRdata <= portBLevel[bitIdx]; // [R10]
      end else begin
        sfrBitRdata <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Pin cells; their pad outputs are registered inside
  port_pin_cell #(
    .WIDTH(WIDTH)
  ) cellA (
    .clk(clk),
    .rst(rst),
    .latch(port_a_data_latch),
    .digitalMode(portADigital), // [R02] [R03]
    .pushPull(port_a_output_mode), // [R05] [R07]
    .highDrive(port_a_drive_strength), // [R08]
    .padIn(portAIn),
    .padOut(portAOut),
    .padOe(portAOe),
    .padPullupEn(portAPullupEn),
    .padRxEn(portARxEn),
    .padHighDrive(portAHighDrive),
    .pinLevel(portALevel)
  );

  port_pin_cell #(
    .WIDTH(WIDTH)
  ) cellB (
    .clk(clk),
    .rst(rst),
    .latch(port_b_data_latch),
    .digitalMode(port_b_input_mode), // [R04] [R03]
    .pushPull(port_b_output_mode), // [R06] [R07]
    .highDrive(port_b_drive_strength), // [R09]
    .padIn(portBIn),
    .padOut(portBOut),
    .padOe(portBOe),
    .padPullupEn(portBPullupEn),
    .padRxEn(portBRxEn),
    .padHighDrive(portBHighDrive),
    .pinLevel(portBLevel)
  );

endmodule

// file: verification/port_pad_model.sv
// Pad model: resolves one port's pins from the block's pad controls.
// Assumes the board driver never fights a pin the block drives.
`timescale 1ns/1ns
module port_pad_model (
  // Clock
  input wire clk,
  // Pad controls
  input wire [7:0] padOut,
  input wire [7:0] padOe,
  input wire [7:0] padPullupEn,
  // Board driver
  input wire [7:0] extEn,
  input wire [7:0] extVal,
  // Pin level
  output wire [7:0] pin
);
  reg [7:0] lastPin = 8'h00;
  // A floating pin flips each cycle, so a stale level never reads as valid
  always @(posedge clk) begin
    lastPin <= pin;
  end
  // Block driver first, then the board, then the weak pull-up
  assign pin = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (padPullupEn | ~lastPin));
endmodule

// file: verification/port2_port3_pin_config_chk.sv
// Checker: bus and pad relations of the two-port pin block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module port2_port3_pin_config_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register bus
  input wire [7:0] sfrPage,
  input wire [7:0] sfrAddr,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrWdata,
  input wire sfrAck,
  input wire [7:0] sfrBitAddr,
  input wire sfrBitWrite,
  input wire sfrBitWdata,
  // Pads
  input wire [7:0] portAOut,
  input wire [7:0] portAOe,
  input wire [7:0] portAPullupEn,
  input wire [7:0] portARxEn,
  input wire [7:0] portAHighDrive,
  input wire [7:0] portBOut,
  input wire [7:0] portBOe,
  input wire [7:0] portBPullupEn,
  input wire [7:0] portBRxEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Latch writes reach the pads two edges later
  a_bdata_write: assert property (
    sfrWrite && sfrAddr == 8'hb0 |=> ##1 portBOut == $past(sfrWdata, 2))
    else $error("port B pads miss byte write");
  a_adata_write: assert property (
    sfrWrite && sfrAddr == 8'ha0 |=> ##1 portAOut == $past(sfrWdata, 2))
    else $error("port A pads miss byte write");
  a_bit_write: assert property (
    sfrBitWrite && sfrBitAddr[7:3] == 5'h16 && !(sfrWrite && sfrAddr == 8'hb0)
    |=> ##1 portBOut[$past(sfrBitAddr[2:0], 2)] == $past(sfrBitWdata, 2))
    else $error("port B pad misses bit write");
  // A low latch is always driven, in either output mode
  a_low_driven: assert property (
    &(portAOut | portAOe) && &(portBOut | portBOe))
    else $error("low latch not driven");
  a_rx_pullup: assert property (
    portARxEn == portAPullupEn && portBRxEn == portBPullupEn && portARxEn[7])
    else $error("receiver and pull-up disagree");
  a_b_inmode: assert property (
    sfrWrite && sfrPage == 8'h0f && sfrAddr == 8'hf1
    |=> ##1 portBRxEn == $past(sfrWdata, 2))
    else $error("port B input mode not applied");
  a_a_drive: assert property (
    sfrWrite && sfrPage == 8'h0f && sfrAddr == 8'ha6
    |=> ##1 portAHighDrive == $past(sfrWdata, 2))
    else $error("port A drive not applied");
  a_data_ack: assert property (
    (sfrRead || sfrWrite) && (sfrAddr == 8'ha0 || sfrAddr == 8'hb0) |=> sfrAck)
    else $error("data latch access not acknowledged");
endmodule

// file: verification/test_port2_port3_pin_config.sv
// Testbench: register and pad checks of the two-port pin block.
// Assumes the pad model resolves pins; inputs change at falling edges.
`timescale 1ns/1ns
module test_port2_port3_pin_config;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] sfrPage = 8'h00, sfrAddr = 8'h00, sfrWdata = 8'h00, sfrBitAddr = 8'h00;
  reg sfrWrite = 1'b0, sfrRead = 1'b0, sfrBitWrite = 1'b0, sfrBitRead = 1'b0;
  reg sfrBitWdata = 1'b0;
  reg [7:0] extEn = 8'h00, extVal = 8'h00;
  wire [7:0] sfrRdata, portAIn, portAOut, portAOe, portAPu, portARx, portAHd;
  wire [7:0] portBIn, portBOut, portBOe, portBPu, portBRx, portBHd;
  wire sfrAck, sfrBitRdata;
  integer failures = 0, compares = 0, i;
  // Mode and drive registers: page, address, reset value
  localparam [47:0] PGS = {8'h0f, 8'h0f, 8'h0f, 8'h00, 8'h0f, 8'h00};
  localparam [47:0] ADS = {8'hf1, 8'hb1, 8'ha1, 8'ha6, 8'ha6, 8'hf3};
  localparam [47:0] RVS = {8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};

  port2_port3_pin_config u_dut (.clk(clk), .rst(rst), .sfrPage(sfrPage),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .sfrAck(sfrAck), .sfrBitAddr(sfrBitAddr),
    .sfrBitWrite(sfrBitWrite), .sfrBitRead(sfrBitRead), .sfrBitWdata(sfrBitWdata),
    .sfrBitRdata(sfrBitRdata), .portAIn(portAIn), .portAOut(portAOut),
    .portAOe(portAOe), .portAPullupEn(portAPu), .portARxEn(portARx),
    .portAHighDrive(portAHd), .portBIn(portBIn), .portBOut(portBOut),
    .portBOe(portBOe), .portBPullupEn(portBPu), .portBRxEn(portBRx),
    .portBHighDrive(portBHd));
  port_pad_model u_padA (.clk(clk), .padOut(portAOut), .padOe(portAOe),
    .padPullupEn(portAPu), .extEn(extEn), .extVal(extVal), .pin(portAIn));
  port_pad_model u_padB (.clk(clk), .padOut(portBOut), .padOe(portBOe),
    .padPullupEn(portBPu), .extEn(8'h00), .extVal(8'h00), .pin(portBIn));

  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Compare, bus access and verdict tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Byte access: one strobe edge, answer looked at on the next falling edge
  task acc(input wr, input [7:0] pg, input [7:0] ad, input [7:0] wd, input [7:0] ex,
    input ea);
    begin
      @(negedge clk);
      sfrPage = pg;
      sfrAddr = ad;
      sfrWdata = wd;
      sfrWrite = wr;
      sfrRead = !wr;
      @(negedge clk);
      sfrWrite = 1'b0;
      sfrRead = 1'b0;
      chk({7'h00, sfrAck}, {7'h00, ea});
      if (!wr) chk(sfrRdata, ex);
    end
  endtask
  task bacc(input wr, input [7:0] ad, input wd, input ex);
    begin
      @(negedge clk);
      sfrBitAddr = ad;
      sfrBitWdata = wd;
      sfrBitWrite = wr;
      sfrBitRead = !wr;
      @(negedge clk);
      sfrBitWrite = 1'b0;
      sfrBitRead = 1'b0;
      if (!wr) chk({7'h00, sfrBitRdata}, {7'h00, ex});
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    failures = failures + 1;
    end_sim;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      acc(0, PGS[8*i +: 8], ADS[8*i +: 8], 8'h00, RVS[8*i +: 8], 1);
    end
    acc(0, 8'h05, 8'hb0, 8'h00, 8'hff, 1);
    // One pattern everywhere; the reserved bit is written as one
    for (i = 0; i < 6; i = i + 1) begin
      acc(1, PGS[8*i +: 8], ADS[8*i +: 8], i == 0 ? 8'hb5 : 8'h35, 8'h00, 1);
    end
    for (i = 0; i < 6; i = i + 1) begin
      acc(0, PGS[8*i +: 8], ADS[8*i +: 8], 8'h00, i == 0 ? 8'hb5 : 8'h35, 1);
    end
    chk(portAOe, 8'h35);
    chk(portAHd, 8'h35);
    chk(portBHd, 8'h35);
    chk(portARx, 8'hb5);
    chk(portBPu, 8'h35);
    // Wrong page is refused and leaves the register alone
    acc(1, 8'h00, 8'ha1, 8'hff, 8'h00, 0);
    acc(0, 8'h05, 8'ha6, 8'h00, 8'h00, 0);
    acc(0, 8'h0f, 8'ha1, 8'h00, 8'h35, 1);
    // Port B: analog pins keep their driver and read back as zero
    acc(1, 8'h05, 8'hb0, 8'h0f, 8'h00, 1);
    repeat (4) @(negedge clk);
    chk(portBOut, 8'h0f);
    chk(portBOe, 8'hf5);
    acc(0, 8'h0f, 8'hb0, 8'h00, 8'h05, 1);
    // Port A: board pulls released open-drain pins
    extEn = 8'hca;
    extVal = 8'h42;
    repeat (4) @(negedge clk);
    acc(0, 8'h00, 8'ha0, 8'h00, 8'h35, 1);
    bacc(0, 8'ha0, 1'b0, 1'b1);
    bacc(0, 8'h90, 1'b0, 1'b0);
    bacc(0, 8'ha7, 1'b0, 1'b0);
    bacc(1, 8'hb3, 1'b0, 1'b0);
    bacc(1, 8'hb6, 1'b1, 1'b0);
    acc(1, 8'h0f, 8'ha0, 8'h7e, 8'h00, 1);
    repeat (2) @(negedge clk);
    chk(portBOut, 8'h47);
    chk(portAOut, 8'h7e);
    end_sim;
  end
endmodule

bind port2_port3_pin_config port2_port3_pin_config_chk u_chk (.clk(clk), .rst(rst),
  .sfrPage(sfrPage), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
  .sfrWdata(sfrWdata), .sfrAck(sfrAck), .sfrBitAddr(sfrBitAddr),
  .sfrBitWrite(sfrBitWrite), .sfrBitWdata(sfrBitWdata), .portAOut(portAOut),
  .portAOe(portAOe), .portAPullupEn(portAPullupEn), .portARxEn(portARxEn),
  .portAHighDrive(portAHighDrive), .portBOut(portBOut), .portBOe(portBOe),
  .portBPullupEn(portBPullupEn), .portBRxEn(portBRxEn));
